// ---- inc/quadrature_counter_compare_map.vh ----
// offsets, field positions and reset values of the quadrature counter
`ifndef QUADRATURE_COUNTER_COMPARE_MAP_VH
`define QUADRATURE_COUNTER_COMPARE_MAP_VH

// control word bit positions (slot outputs 80..95 map to bits 0..15)
`define CW_PRESET_LOAD     0
`define CW_MARKER_GATE     1
`define CW_EQ_CLEAR_LO     2
`define CW_OUT_SEL_LO      6
`define CW_UNDERFLOW_CLEAR 10
`define CW_OVERFLOW_CLEAR  11
`define CW_COUNTER_ENABLE  12
`define CW_FULL_CLEAR      13
`define CW_FORCE_OUTPUTS   14

// data word addresses
`define ADDR_CURRENT       3'h0
`define ADDR_PRESET        3'h1
`define ADDR_SET0          3'h2
`define ADDR_SET3          3'h5
`define ADDR_STATUS        3'h6

// status word bit positions
`define ST_GT_LO           0
`define ST_EQ_LO           4
`define ST_OVERFLOW        8
`define ST_UNDERFLOW       9

// reset values
`define RST_COUNT          16'h0000
`define RST_CONTROL        16'h0000

// highest encoder pulse rate and shortest pulse period
`define MAX_PULSE_KHZ      10
`define CLK_MHZ            200
`define MIN_PULSE_CYCLES   ((`CLK_MHZ * 1000) / `MAX_PULSE_KHZ)

`endif

// ---- rtl/set_value_bank.v ----
// four set values with registered read port and flat value outputs
`timescale 1ns/1ps
`include "quadrature_counter_compare_map.vh"

module set_value_bank #(
  parameter WIDTH   = 16,
  parameter ENTRIES = 4
) (
  input  wire                       core_clk,
  input  wire                       rst,
  input  wire                       wrEn,
  input  wire [1:0]                 wrIndex,
  input  wire [WIDTH-1:0]           wrData,
  input  wire [1:0]                 rdIndex,
  output reg  [WIDTH-1:0]           rdData,
  output wire [WIDTH*ENTRIES-1:0]   allValues
);

  reg [WIDTH-1:0] slot [0:ENTRIES-1];

  genvar i;
  generate
    for (i = 0; i < ENTRIES; i = i + 1)
    begin : gSlot
      always @(posedge core_clk)
      begin
        if (rst)
          slot[i] <= `RST_COUNT;
        else if (wrEn && (wrIndex == i))
          slot[i] <= wrData;
      end
      assign allValues[i*WIDTH +: WIDTH] = slot[i];
    end
  endgenerate

  always @(posedge core_clk)
  begin
    if (rst)
      rdData <= `RST_COUNT;
    else
      rdData <= slot[rdIndex];
  end

endmodule // set_value_bank

// ---- rtl/quadrature_counter_compare.v ----
// quadrature counter with four set-value comparators and output terminals
`timescale 1ns/1ps
`include "quadrature_counter_compare_map.vh"

module quadrature_counter_compare #(
  parameter WIDTH = 16,
  parameter CHANS = 4
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             encA,
  input  wire             encB,
  input  wire             marker,
  input  wire [15:0]      controlWord,
  input  wire             wrEn,
  input  wire [2:0]       wrAddr,
  input  wire [WIDTH-1:0] wrData,
  input  wire             rdEn,
  input  wire [2:0]       rdAddr,
  output reg  [WIDTH-1:0] rdData,
  output reg              rdValid,
  output reg  [CHANS-1:0] compareOut,
  output reg  [WIDTH-1:0] statusWord
);

  reg  [2:0]             syncA;
  reg  [2:0]             syncB;
  reg  [1:0]             syncM;
  reg  [WIDTH-1:0]       count;
  reg  [WIDTH-1:0]       presetValue;
  reg  [CHANS-1:0]       gtFlag;
  reg  [CHANS-1:0]       eqFlag;
  reg                    overflowFlag;
  reg                    underflowFlag;
  reg                    rdPending;
  reg  [2:0]             rdSel;
  reg  [WIDTH-1:0]       next_count;
  reg                    stepUp;
  reg                    stepDown;
  wire [WIDTH-1:0]       bankData;
  wire [WIDTH*CHANS-1:0] setValues;
  wire                   presetLoad;
  wire                   markerGate;
  wire                   counterEnable;
  wire                   fullClear;
  wire                   forceOutputs;
  wire                   underflowClear;
  wire                   overflowClear;
  wire [CHANS-1:0]       eqClear;
  wire [CHANS-1:0]       outSel;
  wire                   bankWr;
  wire                   riseA;
  wire                   fallA;

  assign presetLoad     = controlWord[`CW_PRESET_LOAD];
  assign markerGate     = controlWord[`CW_MARKER_GATE];
  assign eqClear        = controlWord[`CW_EQ_CLEAR_LO +: CHANS];
  assign outSel         = controlWord[`CW_OUT_SEL_LO +: CHANS];
  assign underflowClear = controlWord[`CW_UNDERFLOW_CLEAR];
  assign overflowClear  = controlWord[`CW_OVERFLOW_CLEAR];
  assign counterEnable  = controlWord[`CW_COUNTER_ENABLE];
  assign fullClear      = controlWord[`CW_FULL_CLEAR];
  assign forceOutputs   = controlWord[`CW_FORCE_OUTPUTS];

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      syncM <= 2'h0;
    end
    else
    begin
      syncA <= {syncA[1:0], encA};
      syncB <= {syncB[1:0], encB};
      syncM <= {syncM[0], marker};
    end
  end

  assign riseA = syncA[1] & ~syncA[2];
  assign fallA = ~syncA[1] & syncA[2];

  // up on A rise, down on A fall, both with B low
  always @*
  begin
    stepUp   = riseA & ~syncB[2];
    stepDown = fallA & ~syncB[2];
  end

  always @*
  begin
    next_count = count;
    if (fullClear)
      next_count = `RST_COUNT;
    else if (presetLoad)
      next_count = presetValue;
    else if (markerGate && syncM[1])
      next_count = `RST_COUNT;
    else if (stepUp)
      next_count = count + 1'b1;
    else if (stepDown)
      next_count = count - 1'b1;
  end

  always @(posedge core_clk)
  begin
    if (rst)
      count <= `RST_COUNT;
    else
      count <= next_count;
  end

  always @(posedge core_clk)
  begin
    if (rst || fullClear)
    begin
      overflowFlag  <= 1'b0;
      underflowFlag <= 1'b0;
    end
    else
    begin
      if (overflowClear)
        overflowFlag <= 1'b0;
      else if (!presetLoad && !(markerGate && syncM[1]) && stepUp && (&count))
        overflowFlag <= 1'b1;
      if (underflowClear)
        underflowFlag <= 1'b0;
      else if (!presetLoad && !(markerGate && syncM[1]) && stepDown && (count == `RST_COUNT))
        underflowFlag <= 1'b1;
    end
  end

  // host writes gated by counter enable
  assign bankWr = wrEn && counterEnable && (wrAddr >= `ADDR_SET0) && (wrAddr <= `ADDR_SET3);

  always @(posedge core_clk)
  begin
    if (rst)
      presetValue <= `RST_COUNT;
    else if (wrEn && counterEnable && (wrAddr == `ADDR_PRESET))
      presetValue <= wrData;
  end

  set_value_bank #(
    .WIDTH   (WIDTH),
    .ENTRIES (CHANS)
  ) uBank (
    .core_clk  (core_clk),
    .rst       (rst),
    .wrEn      (bankWr),
    .wrIndex   (wrAddr[1:0] - 2'h2),
    .wrData    (wrData),
    .rdIndex   (rdAddr[1:0] - 2'h2),
    .rdData    (bankData),
    .allValues (setValues)
  );

  genvar c;
  generate
    for (c = 0; c < CHANS; c = c + 1)
    begin : gChan
      always @(posedge core_clk)
      begin
        if (rst || fullClear)
        begin
          gtFlag[c] <= 1'b0;
          eqFlag[c] <= 1'b0;
        end
        else
        begin
          gtFlag[c] <= count > setValues[c*WIDTH +: WIDTH];
          if (eqClear[c])
            eqFlag[c] <= 1'b0;
          else if (count == setValues[c*WIDTH +: WIDTH])
            eqFlag[c] <= 1'b1;
        end
      end

      always @(posedge core_clk)
      begin
        if (rst)
          compareOut[c] <= 1'b0;
        else if (forceOutputs && outSel[c])
          compareOut[c] <= 1'b1;
        else
          compareOut[c] <= outSel[c] ? eqFlag[c] : gtFlag[c];
      end
    end
  endgenerate

  always @(posedge core_clk)
  begin
    if (rst)
      statusWord <= `RST_COUNT;
    else
    begin
      statusWord                          <= `RST_COUNT;
      statusWord[`ST_GT_LO +: CHANS]      <= gtFlag;
      statusWord[`ST_EQ_LO +: CHANS]      <= eqFlag;
      statusWord[`ST_OVERFLOW]            <= overflowFlag;
      statusWord[`ST_UNDERFLOW]           <= underflowFlag;
    end
  end

  // host reads gated by counter enable, two-cycle answer
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      rdPending <= 1'b0;
      rdSel     <= 3'h0;
      rdValid   <= 1'b0;
      rdData    <= `RST_COUNT;
    end
    else
    begin
      rdPending <= rdEn && counterEnable;
      rdValid   <= rdPending;
      if (rdEn)
        rdSel <= rdAddr;
      if (rdPending)
      begin
        case (rdSel)
          `ADDR_CURRENT: rdData <= count;
          `ADDR_PRESET:  rdData <= presetValue;
          `ADDR_STATUS:  rdData <= statusWord;
          3'h2, 3'h3, 3'h4, 3'h5: rdData <= bankData;
          default:       rdData <= `RST_COUNT;
        endcase
      end
    end
  end

endmodule // quadrature_counter_compare

// ---- verif/quadrature_counter_compare_properties.sv ----
// port assertions for the quadrature counter
`timescale 1ns/1ps
module quadrature_counter_compare_properties #(
  parameter WIDTH = 16,
  parameter CHANS = 4
) (
  input wire             core_clk,
  input wire             rst,
  input wire             encA,
  input wire             encB,
  input wire             marker,
  input wire [15:0]      controlWord,
  input wire             wrEn,
  input wire [2:0]       wrAddr,
  input wire [WIDTH-1:0] wrData,
  input wire             rdEn,
  input wire [2:0]       rdAddr,
  input wire [WIDTH-1:0] rdData,
  input wire             rdValid,
  input wire [CHANS-1:0] compareOut,
  input wire [WIDTH-1:0] statusWord
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  read_answer_a: assert property (rdEn && controlWord[12] |-> ##2 rdValid)
    else $error("read not answered after two cycles");
  read_cause_a: assert property (rdValid |-> $past(rdEn, 2) && $past(controlWord[12], 2))
    else $error("read answer without enabled request");
  data_hold_a: assert property (!rdValid && !$past(rst) |-> $stable(rdData))
    else $error("read data moved without answer");
  status_spare_a: assert property (statusWord[15:10] == 6'h00)
    else $error("spare status bits set");
  under_clear_a: assert property (controlWord[10] [*3] |-> !statusWord[9])
    else $error("underflow flag kept while cleared");
  over_clear_a: assert property (controlWord[11] [*3] |-> !statusWord[8])
    else $error("overflow flag kept while cleared");
  equal_clear_a: assert property (controlWord[2] [*3] |-> !statusWord[4])
    else $error("equal flag kept while cleared");
  equal_latch_a: assert property (statusWord[4] && !controlWord[2] && !$past(controlWord[2])
    && !controlWord[13] && !$past(controlWord[13]) |=> statusWord[4])
    else $error("equal flag dropped without clear");
  full_clear_a: assert property (controlWord[13] [*4] |-> (statusWord & 16'h030F) == 16'h0000)
    else $error("flags survive full clear");
  out_route_a: assert property ($stable(controlWord) [*3] |-> compareOut[0] ==
    (controlWord[6] ? (controlWord[14] | statusWord[4]) : statusWord[0]))
    else $error("terminal source wrong");
  cover property (rdValid);
  cover property (statusWord[9] && statusWord[8]);
  cover property (compareOut[2] && controlWord[14]);
endmodule // quadrature_counter_compare_properties

bind quadrature_counter_compare quadrature_counter_compare_properties #(.WIDTH(WIDTH), .CHANS(CHANS)) i_props (
  .core_clk    (core_clk),
  .rst         (rst),
  .encA        (encA),
  .encB        (encB),
  .marker      (marker),
  .controlWord (controlWord),
  .wrEn        (wrEn),
  .wrAddr      (wrAddr),
  .wrData      (wrData),
  .rdEn        (rdEn),
  .rdAddr      (rdAddr),
  .rdData      (rdData),
  .rdValid     (rdValid),
  .compareOut  (compareOut),
  .statusWord  (statusWord)
);

// ---- verif/quad_encoder_model.sv ----
// behavioural two-phase encoder with marker output
`timescale 1ns/1ps
module quad_encoder_model #(
  parameter PHASE_CYCLES = 4
) (
  input  wire core_clk,
  output reg  encA = 1'b0,
  output reg  encB = 1'b0,
  output reg  marker = 1'b0
);
  // level held per phase, shortened rate
  task phase(input a, input b);
  begin
    encA = a;
    encB = b;
    repeat (PHASE_CYCLES) @(negedge core_clk);
  end
  endtask
  task step(input up);
  begin
    phase(up, ~up);
    phase(1'b1, 1'b1);
    phase(~up, up);
    phase(1'b0, 1'b0);
  end
  endtask
  task mark;
  begin
    marker = 1'b1;
    repeat (8) @(negedge core_clk);
    marker = 1'b0;
  end
  endtask
endmodule // quad_encoder_model

// ---- verif/tb_top.sv ----
// self-checking bench for the quadrature counter
`timescale 1ns/1ps
module tb_top;
  reg         core_clk = 1'b0, rst = 1'b1, wrEn, rdEn;
  reg  [15:0] controlWord, wrData;
  reg  [2:0]  wrAddr, rdAddr;
  reg  [18:0] rows [0:4];
  wire        encA, encB, marker, rdValid;
  wire [15:0] rdData, statusWord;
  wire [3:0]  compareOut;
  integer     err_count = 0, cmp_count = 0, i;
  initial forever #2.5 core_clk = ~core_clk;
  quadrature_counter_compare i_quadrature_counter_compare (
    .core_clk    (core_clk),
    .rst         (rst),
    .encA        (encA),
    .encB        (encB),
    .marker      (marker),
    .controlWord (controlWord),
    .wrEn        (wrEn),
    .wrAddr      (wrAddr),
    .wrData      (wrData),
    .rdEn        (rdEn),
    .rdAddr      (rdAddr),
    .rdData      (rdData),
    .rdValid     (rdValid),
    .compareOut  (compareOut),
    .statusWord  (statusWord)
  );
  quad_encoder_model enc (
    .core_clk (core_clk),
    .encA     (encA),
    .encB     (encB),
    .marker   (marker)
  );
  task chk(input [15:0] s, input [15:0] e, input [8*6:1] n);
  begin
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("wrong value %0s exp %h seen %h", n, e, s);
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task rd(input [2:0] a, input [15:0] e);
  begin
    rdEn = 1'b1;
    rdAddr = a;
    cyc(1);
    rdEn = 1'b0;
    cyc(1);
    chk(rdValid, 16'h0001, "valid");
    chk(rdData, e, "rdata");
  end
  endtask
  task done(input [8*6:1] n);
    $display("test %0s done", n);
  endtask
  task end_sim;
  begin
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    #40000;
    err_count = err_count + 1;
    end_sim;
  end
  initial
  begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    controlWord = 16'h0000;
    wrData = 16'h0000;
    wrAddr = 3'h0;
    rdAddr = 3'h0;
    rows[0] = {3'h1, 16'h0005};
    rows[1] = {3'h2, 16'h0002};
    rows[2] = {3'h3, 16'h0003};
    rows[3] = {3'h4, 16'hFFFF};
    rows[4] = {3'h5, 16'h0000};
    cyc(8);
    rst = 1'b0;
    chk(statusWord, 16'h0000, "status");
    chk(compareOut, 16'h0000, "out");
    done("reset");
    cyc(3);
    controlWord = 16'h3002;
    cyc(1);
    controlWord = 16'h1002;
    for (i = 0; i < 5; i = i + 1)
    begin
      wrEn = 1'b1;
      wrAddr = rows[i][18:16];
      wrData = rows[i][15:0];
      cyc(1);
      wrEn = 1'b0;
      rd(rows[i][18:16], rows[i][15:0]);
    end
    done("table");
    controlWord = 16'h103E;
    cyc(2);
    controlWord = 16'h1002;
    for (i = 0; i < 3; i = i + 1)
      enc.step(1'b1);
    rd(3'h0, 16'h0003);
    chk(statusWord, 16'h00B9, "status");
    enc.step(1'b0);
    rd(3'h0, 16'h0002);
    chk(statusWord, 16'h00B8, "status");
    done("count");
    controlWord = 16'h10C2;
    cyc(4);
    chk(compareOut, 16'h000B, "out");
    controlWord = 16'h5102;
    cyc(4);
    chk(compareOut, 16'h000C, "out");
    controlWord = 16'h1006;
    cyc(4);
    chk(statusWord[7:4], 16'h000A, "equal");
    rd(3'h6, 16'h00A8);
    done("output");
    controlWord = 16'h1003;
    enc.step(1'b1);
    rd(3'h0, 16'h0005);
    controlWord = 16'h1000;
    enc.mark;
    rd(3'h0, 16'h0005);
    controlWord = 16'h1002;
    enc.mark;
    rd(3'h0, 16'h0000);
    done("marker");
    enc.step(1'b0);
    rd(3'h0, 16'hFFFF);
    enc.step(1'b1);
    chk(statusWord[9:8], 16'h0003, "wrap");
    controlWord = 16'h1402;
    cyc(4);
    chk(statusWord[9:8], 16'h0001, "wrap");
    controlWord = 16'h1002;
    enc.step(1'b1);
    controlWord = 16'h3002;
    cyc(4);
    chk(statusWord & 16'h030F, 16'h0000, "clear");
    rd(3'h0, 16'h0000);
    controlWord = 16'h1002;
    enc.step(1'b0);
    enc.step(1'b1);
    controlWord = 16'h1802;
    cyc(4);
    chk(statusWord[9:8], 16'h0002, "wrap");
    done("wrap");
    controlWord = 16'h0002;
    wrEn = 1'b1;
    wrAddr = 3'h2;
    cyc(1);
    wrEn = 1'b0;
    rdEn = 1'b1;
    rdAddr = 3'h1;
    cyc(1);
    rdEn = 1'b0;
    cyc(1);
    chk(rdValid, 16'h0000, "valid");
    chk(rdData, 16'h0000, "rdata");
    controlWord = 16'h1002;
    rd(3'h2, 16'h0002);
    rd(3'h7, 16'h0000);
    done("refuse");
    end_sim;
  end
endmodule // tb_top
